//--- rtl/gpio_port_pkg.sv
// Package for the eight-pin bidirectional port with peripheral overrides
package gpio_port_pkg;
   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam int          ADDR_W                   = 4;
   localparam int          PORT_W                   = 8;
   localparam logic [3:0]  PIN_DATA_OFFSET          = 4'h0;
   localparam logic [3:0]  DIRECTION_OFFSET         = 4'h1;
   localparam logic [3:0]  OVR_SELECT_OFFSET        = 4'h2;
   localparam logic [3:0]  LEVEL_CTRL_OFFSET        = 4'h3;
   localparam logic [7:0]  PIN_DATA_RESET           = 8'h00;
   localparam logic [7:0]  DIRECTION_RESET          = 8'hff;
   localparam logic [7:0]  OVR_SELECT_RESET         = 8'h00;
   localparam int          LEVEL_SEL_BIT            = 6;
   localparam int          SERIAL_PIN_LO            = 3;
   localparam int          SERIAL_PIN_HI            = 4;
   localparam logic [7:0]  UNMAPPED_READ            = 8'h00;

   // Register bus request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [3:0]        addr;
      logic [7:0]        wdata;
   } reg_req_t;

   // Per-pin peripheral override request
   typedef struct packed {
      logic [7:0]        enable;
      logic [7:0]        force_out;
      logic [7:0]        force_in;
      logic [7:0]        out_val;
   } periph_ovr_t;
endpackage : gpio_port_pkg

//--- rtl/bidir_port_with_overrides.sv
// Eight-pin bidirectional port with direction register and overrides
// Notes on behaviour
// - Eight bidirectional pins, each with its own direction bit.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero drives the pin from the output latch.
// - An enabled peripheral may force its pin to be an output.
// - Another enabled peripheral may force its pin to be an input.
// - Overrides hold only while the peripheral is enabled.
// - Peripheral output enable acts only when peripheral is selected.
// - Two-wire enabled: status bit 6 picks bus levels on pins 4 and 3.
module bidir_port_with_overrides
   import gpio_port_pkg::*;
(
   input  wire logic                      sys_clk_i,
   input  wire logic                      reset_i,
   input  wire logic                      clk_en_i,
   input  wire gpio_port_pkg::reg_req_t   reg_req_i,
   output logic [7:0]                     reg_rdata_o,
   input  wire gpio_port_pkg::periph_ovr_t periph_ovr_i,
   input  wire logic                      serial_enable_i,
   input  wire logic [7:0]                serial_port_status_i,
   output logic                           serial_smbus_levels_o,
   input  wire logic [7:0]                pin_i,
   output logic [7:0]                     pin_o,
   output logic [7:0]                     pin_oe_n_o,
   output logic [7:0]                     periph_pin_o
);
   import gpio_port_pkg::*;

   // ***********************************************************
   // Decoding helpers
   // ***********************************************************
   // Request addresses the given register
   function automatic logic hit(input reg_req_t   r,
                                input logic [3:0] a);
      return r.addr == a;
   endfunction

   // Write to the given register taken on this edge
   function automatic logic wr_hit(input logic       en,
                                   input reg_req_t   r,
                                   input logic [3:0] a);
      return en && r.wr && hit(r, a);
   endfunction

   // Read taken on this edge
   function automatic logic rd_take(input logic     en,
                                    input reg_req_t r);
      return en && r.rd;
   endfunction

   // ***********************************************************
   // Storage and next values
   // ***********************************************************
   logic [7:0] out_latch_q;
   logic [7:0] out_latch_d;
   logic [7:0] third_port_direction_q;
   logic [7:0] third_port_direction_d;
   logic [7:0] ovr_select_q;
   logic [7:0] ovr_select_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       wr_latch;
   logic       wr_dir;
   logic       wr_sel;
   logic       rd_now;
   logic [7:0] sel_en;
   logic [7:0] want_out;
   logic [7:0] want_in;
   logic [7:0] pin_dir_in;
   logic [7:0] pin_drive;

   // ***********************************************************
   // Write and read strobes
   // ***********************************************************
   // Clock enable low turns every strobe off, freezing all state except when reset_i loads the reset values
   assign wr_latch = wr_hit(clk_en_i, reg_req_i, PIN_DATA_OFFSET);
   assign wr_dir   = wr_hit(clk_en_i, reg_req_i, DIRECTION_OFFSET);
   assign wr_sel   = wr_hit(clk_en_i, reg_req_i, OVR_SELECT_OFFSET);
   assign rd_now   = rd_take(clk_en_i, reg_req_i);

   // ***********************************************************
   // Output latch
   // ***********************************************************
   // Written whatever the pin direction, so a pin turned to output
   // later drives the value that software prepared
   always_comb begin
      out_latch_d = out_latch_q;
      if (wr_latch) begin
         out_latch_d = reg_req_i.wdata;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         out_latch_q <= PIN_DATA_RESET;
      end else begin
         out_latch_q <= out_latch_d;
      end
   end

   // ***********************************************************
   // Direction register
   // ***********************************************************
   // Reads return this register, never the overridden direction, so
   // a read-modify-write during an override keeps the stored bits
   always_comb begin
      third_port_direction_d = third_port_direction_q;
      if (wr_dir) begin
         third_port_direction_d = reg_req_i.wdata;
      end
   end

   // All pins start as inputs, so nothing drives before software
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         third_port_direction_q <= DIRECTION_RESET;
      end else begin
         third_port_direction_q <= third_port_direction_d;
      end
   end

   // ***********************************************************
   // Override select
   // ***********************************************************
   // Which pins hand their function to a peripheral
   always_comb begin
      ovr_select_d = ovr_select_q;
      if (wr_sel) begin
         ovr_select_d = reg_req_i.wdata;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ovr_select_q <= OVR_SELECT_RESET;
      end else begin
         ovr_select_q <= ovr_select_d;
      end
   end

   // ***********************************************************
   // Read path
   // ***********************************************************
   // Read data hold until the next taken read
   always_comb begin
      rdata_d = rdata_q;
      if (rd_now) begin
         unique case (reg_req_i.addr)
            PIN_DATA_OFFSET:   rdata_d = pin_i;
            DIRECTION_OFFSET:  rdata_d = third_port_direction_q;
            OVR_SELECT_OFFSET: rdata_d = ovr_select_q;
            LEVEL_CTRL_OFFSET: rdata_d = {7'h00, serial_smbus_levels_o};
            default:           rdata_d = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rdata_q <= UNMAPPED_READ;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ***********************************************************
   // Peripheral arbitration
   // ***********************************************************
   // A peripheral counts only while enabled and selected for the pin
   assign sel_en = periph_ovr_i.enable & ovr_select_q;

   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      // An output request beats an input request on the same pin
      assign want_out[i] = sel_en[i] & periph_ovr_i.force_out[i];
      assign want_in[i]  = sel_en[i] & periph_ovr_i.force_in[i]
                           & ~want_out[i];

      always_comb begin
         if (want_out[i]) begin
            pin_dir_in[i] = 1'b0;
            pin_drive[i]  = periph_ovr_i.out_val[i];
         end else if (want_in[i]) begin
            pin_dir_in[i] = 1'b1;
            pin_drive[i]  = out_latch_q[i];
         end else begin
            pin_dir_in[i] = third_port_direction_q[i];
            pin_drive[i]  = out_latch_q[i];
         end
      end
   end

   // ***********************************************************
   // Pin outputs
   // ***********************************************************
   // Output enable is active low: zero while the port drives the pin
   assign pin_oe_n_o   = pin_dir_in;
   assign pin_o        = pin_drive;

   // Peripherals always see the pin level, whatever owns the driver
   assign periph_pin_o = pin_i;

   // ***********************************************************
   // Serial pin levels
   // ***********************************************************
   // Picks the input levels of the two serial pins; only meaningful
   // while the two-wire module is enabled
   assign serial_smbus_levels_o =
      serial_enable_i && serial_port_status_i[LEVEL_SEL_BIT];
endmodule // bidir_port_with_overrides

//--- tb/port_monitor.sv
// Checker on pin drive, overrides and register reads
module port_monitor import gpio_port_pkg::*; (
   input wire logic sys_clk_i, reset_i, clk_en_i, serial_enable_i,
   input wire logic serial_smbus_levels_o,
   input wire reg_req_t reg_req_i,
   input wire periph_ovr_t periph_ovr_i,
   input wire logic [7:0] serial_port_status_i, reg_rdata_o, pin_i, pin_o,
   input wire logic [7:0] pin_oe_n_o, periph_pin_o);
   timeunit 1ns; timeprecision 1ns;
   logic [7:0] sel_q;
   wire [3:0] ad = reg_req_i.addr;
   wire [7:0] en = periph_ovr_i.enable & sel_q, wd = reg_req_i.wdata;
   wire [7:0] fo = en & periph_ovr_i.force_out;
   wire [7:0] fi = en & periph_ovr_i.force_in & ~fo;
   wire wa = clk_en_i && reg_req_i.wr, q = periph_ovr_i.enable == 8'h00;
   // Mirror of the override select, to know which pins a peripheral owns
   always_ff @(posedge sys_clk_i)
      if (reset_i) sel_q <= 8'h00;
      else if (wa && ad == 4'h2) sel_q <= wd;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_dir_write: assert property (wa && ad == 4'h1 ##1 q
      |-> pin_oe_n_o == $past(wd)) else $error("dir");
   a_latch_out: assert property (wa && ad == 4'h0 ##1 q
      |-> ((pin_o ^ $past(wd)) & ~pin_oe_n_o) == 8'h00) else $error("latch");
   a_force_out: assert property ((pin_oe_n_o & fo) == 8'h00)
      else $error("out");
   a_force_in: assert property ((pin_oe_n_o & fi) == fi)
      else $error("in");
   a_ovr_val: assert property (
      ((pin_o ^ periph_ovr_i.out_val) & fo) == 8'h00) else $error("val");
   a_level_sel: assert property (
      serial_smbus_levels_o == (serial_enable_i && serial_port_status_i[6]))
      else $error("level");
   a_read_pins: assert property (clk_en_i && reg_req_i.rd && ad == 4'h0
      |=> reg_rdata_o == $past(pin_i)) else $error("read");
   a_pin_copy: assert property (periph_pin_o == pin_i)
      else $error("copy");
   a_rdata_hold: assert property (!(clk_en_i && reg_req_i.rd)
      |=> $stable(reg_rdata_o)) else $error("hold");
endmodule // port_monitor

//--- tb/pad_model.sv
// Pads: driven pins echo the port, released pins show a toggling level
module pad_model (
   input  wire logic [7:0] pin_o, pin_oe_n_o, ext_i,
   output logic [7:0]      pin_i);
   timeunit 1ns; timeprecision 1ns;
   assign pin_i = pin_o & ~pin_oe_n_o | ext_i & pin_oe_n_o;
endmodule // pad_model

//--- tb/tb_top.sv
// Bench for the eight-pin port
module tb_top;
   timeunit 1ns; timeprecision 1ns;
   import gpio_port_pkg::*;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1;
   logic serial_enable_i = 1'b0, serial_smbus_levels_o;
   logic [7:0] serial_port_status_i = 8'h00, ext_i = 8'h5a, x, reg_rdata_o;
   logic [7:0] pin_i, pin_o, pin_oe_n_o, periph_pin_o;
   reg_req_t reg_req_i = '0;
   periph_ovr_t periph_ovr_i = '0;
   int n_fail = 0, total_checks = 0, cyc = 0;
   bidir_port_with_overrides dut (.*);
   pad_model pads (.*);
   initial forever #50 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      ext_i <= ~ext_i; cyc <= cyc + 1;
      if (cyc == 900) begin n_fail++; complete_run; end
   end
   task automatic chk(input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, logic [3:0] a, logic [7:0] d, m = 8'h00);
      @(posedge sys_clk_i) reg_req_i <= '{w, !w, a, d};
      @(posedge sys_clk_i) reg_req_i <= '0;
      x = ext_i; #1;
      if (!w) chk(reg_rdata_o, d & ~m | x & m);
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0; #1 chk(pin_oe_n_o, 8'hff);
      acc(1'b0, 4'h1, 8'hff);
      acc(1'b1, 4'h0, 8'h3c); acc(1'b1, 4'h1, 8'hf0);
      chk(pin_oe_n_o, 8'hf0);
      acc(1'b0, 4'h0, 8'h3c, 8'hf0);
      acc(1'b1, 4'h0, 8'hc3); acc(1'b1, 4'h1, 8'h01);
      acc(1'b1, 4'h2, 8'h81); chk(pin_o | 8'h01, 8'hc3);
      @(posedge sys_clk_i) periph_ovr_i <= '{8'h83, 8'h01, 8'h82, 8'h01};
      #1 chk(pin_oe_n_o, 8'h80);
      chk(pin_o & 8'h03, 8'h03);
      @(posedge sys_clk_i) periph_ovr_i <= '0;
      #1 chk(pin_oe_n_o, 8'h01);
      $display("port tests done");
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i)
            {serial_enable_i, serial_port_status_i[6]} <= 2'(i);
         #1 chk({7'h00, serial_smbus_levels_o}, 8'(i == 3));
      end
      acc(1'b0, 4'h3, 8'h01);
      acc(1'b0, 4'hf, 8'h00);
      $display("serial tests done");
      acc(1'b0, 4'h2, 8'h81);
      @(posedge sys_clk_i) clk_en_i <= 1'b0;
      acc(1'b1, 4'h1, 8'h55); acc(1'b0, 4'h1, 8'h81);
      @(posedge sys_clk_i) clk_en_i <= 1'b1;
      acc(1'b0, 4'h1, 8'h01);
      $display("enable tests done");
      @(posedge sys_clk_i) reset_i <= 1'b1;
      @(posedge sys_clk_i) reset_i <= 1'b0;
      #1 chk(pin_oe_n_o, 8'hff);
      chk(pin_o, 8'h00);
      acc(1'b0, 4'h2, 8'h00);
      $display("reset tests done");
      complete_run;
   end
endmodule // tb_top
bind bidir_port_with_overrides port_monitor mon (.*);
